// [include/port_function_control_pkg.sv]
package port_function_control_pkg;

    // ==========================================================
    // Special register addresses
    // ==========================================================
    localparam logic [15:0] ADDR_MEMORY_EXPANSION_MODE = 16'hFF47;
    localparam logic [15:0] ADDR_PORT2_DRIVE_TYPE      = 16'hFF52;
    localparam logic [15:0] ADDR_PORT5_SEGMENT_SELECT  = 16'hFF55;
    localparam logic [15:0] ADDR_PORT7_SEGMENT_SELECT  = 16'hFF57;
    localparam logic [15:0] ADDR_PORT12_SEGMENT_SELECT = 16'hFF5C;
    localparam logic [15:0] ADDR_PORT13_SEGMENT_SELECT = 16'hFF5D;
    localparam logic [15:0] ADDR_PORT14_SEGMENT_SELECT = 16'hFF5E;
    // Output latch at PORT_LATCH_BASE + port number, direction at
    // PIN_DIRECTION_BASE + port number
    localparam logic [15:0] PORT_LATCH_BASE            = 16'hFF00;
    localparam logic [15:0] PIN_DIRECTION_BASE         = 16'hFF20;
    localparam logic [15:0] SFR_BASE                   = 16'hFF00;

    // ==========================================================
    // Field layout and reset values
    // ==========================================================
    localparam logic [7:0] DRIVE_TYPE_MASK   = 8'h1F;
    localparam logic [7:0] EXPANSION_MASK    = 8'h07;
    localparam logic [7:0] SELECT_RESET      = 8'h00;
    localparam logic [7:0] LATCH_RESET       = 8'h00;
    localparam logic [7:0] DIRECTION_RESET   = 8'hFF;
    localparam logic [7:0] SEGMENT_ALL_ZERO  = 8'h00;
    localparam logic [7:0] SEGMENT_ALL_ONE   = 8'hFF;

    // ==========================================================
    // Expansion mode codes
    // ==========================================================
    localparam logic [2:0] MODE_SINGLE_CHIP  = 3'h0;
    localparam logic [2:0] MODE_EXPAND_256   = 3'h3;
    localparam logic [2:0] MODE_EXPAND_4K    = 3'h4;
    localparam logic [2:0] MODE_EXPAND_16K   = 3'h5;
    localparam logic [2:0] MODE_EXPAND_FULL  = 3'h7;
    localparam logic [16:0] SIZE_256         = 17'h00100;
    localparam logic [16:0] SIZE_4K          = 17'h01000;
    localparam logic [16:0] SIZE_16K         = 17'h04000;
    localparam logic [16:0] SIZE_FULL        = 17'h10000;

    // ==========================================================
    // Ports served, in array order
    // ==========================================================
    localparam int NUM_PORTS = 8;
    localparam logic [7:0] PORT_NUMBER [0:NUM_PORTS-1] =
        '{8'h02, 8'h04, 8'h05, 8'h06, 8'h07, 8'h0C, 8'h0D, 8'h0E};
    localparam int IDX_P2  = 0;
    localparam int IDX_P4  = 1;
    localparam int IDX_P5  = 2;
    localparam int IDX_P6  = 3;
    localparam int IDX_P7  = 4;
    localparam int IDX_P12 = 5;
    localparam int IDX_P13 = 6;
    localparam int IDX_P14 = 7;

    // Port 6 strobe pin positions
    localparam int PIN_READ_STROBE  = 4;
    localparam int PIN_WRITE_STROBE = 5;
    localparam int PIN_ADDR_STROBE  = 7;

endpackage : port_function_control_pkg

// [src/port_io.sv]
`timescale 1ns/10ps
// One byte-wide port: output latch, direction register, read path
module port_io
    import port_function_control_pkg::*;
(
    input  wire logic       sys_clk_i,
    input  wire logic       rstn_i,
    input  wire logic       latch_wr_i,
    input  wire logic       dir_wr_i,
    input  wire logic [7:0] wdata_i,
    input  wire logic [7:0] pin_level_i,
    output logic      [7:0] latch_o,
    output logic      [7:0] pin_direction_bit_o,
    output logic      [7:0] read_value_o
);

    // ==========================================================
    // Output latch
    // ==========================================================
    // Written whatever the direction; only writes change it
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            latch_o <= LATCH_RESET;
        end else if (latch_wr_i) begin
            latch_o <= wdata_i;
        end
    end

    // ==========================================================
    // Direction: 0 drives, 1 is input
    // ==========================================================
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            pin_direction_bit_o <= DIRECTION_RESET;
        end else if (dir_wr_i) begin
            pin_direction_bit_o <= wdata_i;
        end
    end

    // Output pins read the latch, input pins the pin level
    assign read_value_o = (latch_o & ~pin_direction_bit_o)
                        | (pin_level_i & pin_direction_bit_o);

endmodule : port_io

// [src/port_function_control.sv]
`timescale 1ns/10ps
module port_function_control
    import port_function_control_pkg::*;
#(
    parameter logic [15:0] ROM_SIZE  = 16'h8000,
    parameter logic [15:0] RAM_START = 16'hFB00
) (
    input  wire logic        sys_clk_i,
    input  wire logic        rstn_i,
    // CPU special register access
    input  wire logic [15:0] sfr_addr_i,
    input  wire logic        sfr_wr_i,
    input  wire logic        sfr_bit_wr_i,
    input  wire logic [2:0]  sfr_bit_sel_i,
    input  wire logic        sfr_bit_val_i,
    input  wire logic [7:0]  sfr_wdata_i,
    input  wire logic        sfr_rd_i,
    output logic      [7:0]  sfr_rdata_o,
    // CPU external access request
    input  wire logic [15:0] ext_addr_i,
    input  wire logic [7:0]  ext_wdata_i,
    input  wire logic        ext_rd_i,
    input  wire logic        ext_wr_i,
    input  wire logic        ext_addr_phase_i,
    output logic             ext_select_o,
    output logic      [7:0]  ext_rdata_o,
    // Pins
    input  wire logic [7:0]  pin_level_i [NUM_PORTS],
    output logic      [7:0]  pin_out_o   [NUM_PORTS],
    output logic      [7:0]  pin_oe_o    [NUM_PORTS],
    // LCD segment hand-over per segment-capable port
    output logic      [7:0]  seg_enable_o [5],
    output logic      [2:0]  expansion_code_o
);

    // The window decode needs RAM to sit above the ROM
    if (RAM_START <= ROM_SIZE) begin : g_bad_map
        $error("RAM_START must lie above the internal ROM");
    end

    // ==========================================================
    // Control registers
    // ==========================================================
    logic [7:0] memory_expansion_mode;
    logic [7:0] port2_drive_type;
    logic [7:0] port5_segment_select;
    logic [7:0] port7_segment_select;
    logic [7:0] port12_segment_select;
    logic [7:0] port13_segment_select;
    logic [7:0] port14_segment_select;

    logic [7:0] latch      [NUM_PORTS];
    logic [7:0] direction  [NUM_PORTS];
    logic [7:0] port_read  [NUM_PORTS];
    logic [NUM_PORTS-1:0] latch_hit;
    logic [NUM_PORTS-1:0] dir_hit;
    logic [7:0] read_value;
    logic [7:0] next_value;
    logic       any_write;
    logic       byte_only;

    // Match an address to latch or direction of port number n
    function automatic logic hit_at(input logic [15:0] base,
                                    input logic [7:0]  n,
                                    input logic [15:0] addr);
        hit_at = (addr == (base + {8'h00, n}));
    endfunction : hit_at

    // Read mux, also the source of bit operations
    always_comb begin
        read_value = 8'h00;
        latch_hit  = '0;
        dir_hit    = '0;
        for (int i = 0; i < NUM_PORTS; i++) begin
            latch_hit[i] = hit_at(PORT_LATCH_BASE, PORT_NUMBER[i],
                                  sfr_addr_i);
            dir_hit[i]   = hit_at(PIN_DIRECTION_BASE, PORT_NUMBER[i],
                                  sfr_addr_i);
            if (latch_hit[i]) read_value = port_read[i];
            if (dir_hit[i])   read_value = direction[i];
        end

        unique case (sfr_addr_i)
            ADDR_MEMORY_EXPANSION_MODE: read_value = memory_expansion_mode;
            ADDR_PORT2_DRIVE_TYPE:      read_value = port2_drive_type;
            ADDR_PORT5_SEGMENT_SELECT:  read_value = port5_segment_select;
            ADDR_PORT7_SEGMENT_SELECT:  read_value = port7_segment_select;
            ADDR_PORT12_SEGMENT_SELECT: read_value = port12_segment_select;
            ADDR_PORT13_SEGMENT_SELECT: read_value = port13_segment_select;
            ADDR_PORT14_SEGMENT_SELECT: read_value = port14_segment_select;
            default: ;
        endcase
    end

    // Bit operations rewrite the whole byte read back
    always_comb begin
        next_value = sfr_wdata_i;
        if (sfr_bit_wr_i) begin
            next_value = read_value;
            next_value[sfr_bit_sel_i] = sfr_bit_val_i;
        end
    end

    // Bit writes store the whole byte
    assign any_write = sfr_wr_i | sfr_bit_wr_i;
    assign byte_only = sfr_wr_i & ~sfr_bit_wr_i;

    // Mode and drive-type registers, unused bits held at zero
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            memory_expansion_mode <= SELECT_RESET;
            port2_drive_type      <= SELECT_RESET;
        end else if (any_write) begin
            if (sfr_addr_i == ADDR_MEMORY_EXPANSION_MODE) begin
                memory_expansion_mode <= next_value & EXPANSION_MASK;
            end
            if (sfr_addr_i == ADDR_PORT2_DRIVE_TYPE) begin
                port2_drive_type <= next_value & DRIVE_TYPE_MASK;
            end
        end
    end

    // Segment selects; ports 12-14 ignore bit operations
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            port5_segment_select  <= SELECT_RESET;
            port7_segment_select  <= SELECT_RESET;
            port12_segment_select <= SELECT_RESET;
            port13_segment_select <= SELECT_RESET;
            port14_segment_select <= SELECT_RESET;
        end else begin
            if (any_write && sfr_addr_i == ADDR_PORT5_SEGMENT_SELECT) begin
                port5_segment_select <= next_value;
            end
            if (any_write && sfr_addr_i == ADDR_PORT7_SEGMENT_SELECT) begin
                port7_segment_select <= next_value;
            end

            // Mixed patterns are software's fault and are stored as is
            if (byte_only && sfr_addr_i == ADDR_PORT12_SEGMENT_SELECT) begin
                port12_segment_select <= sfr_wdata_i;
            end
            if (byte_only && sfr_addr_i == ADDR_PORT13_SEGMENT_SELECT) begin
                port13_segment_select <= sfr_wdata_i;
            end
            if (byte_only && sfr_addr_i == ADDR_PORT14_SEGMENT_SELECT) begin
                port14_segment_select <= sfr_wdata_i;
            end
        end
    end

    // Registered read data; reads have no side effect
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            sfr_rdata_o <= 8'h00;
        end else if (sfr_rd_i) begin
            sfr_rdata_o <= read_value;
        end
    end

    // ==========================================================
    // Port latches and directions
    // ==========================================================
    for (genvar g = 0; g < NUM_PORTS; g++) begin : g_port
        port_io u_port (
            .sys_clk_i           (sys_clk_i),
            .rstn_i              (rstn_i),
            .latch_wr_i          (any_write & latch_hit[g]),
            .dir_wr_i            (any_write & dir_hit[g]),
            .wdata_i             (next_value),
            .pin_level_i         (pin_level_i[g]),
            .latch_o             (latch[g]),
            .pin_direction_bit_o (direction[g]),
            .read_value_o        (port_read[g])
        );
    end

    // ==========================================================
    // External memory window
    // ==========================================================
    logic [2:0]  expansion_code;
    logic        expand_on;
    logic [16:0] window_size;
    logic        internal_hit;
    logic [16:0] ext_offset;

    assign expansion_code   = memory_expansion_mode[2:0];
    assign expansion_code_o = expansion_code;
    assign expand_on        = (expansion_code != MODE_SINGLE_CHIP);

    always_comb begin
        unique case (expansion_code)
            MODE_EXPAND_256:  window_size = SIZE_256;
            MODE_EXPAND_4K:   window_size = SIZE_4K;
            MODE_EXPAND_16K:  window_size = SIZE_16K;
            MODE_EXPAND_FULL: window_size = SIZE_FULL;
            default:          window_size = 17'h00000;
        endcase
    end

    // Internal ROM, RAM and special registers never go outside
    assign internal_hit = (ext_addr_i < ROM_SIZE)
                        | (ext_addr_i >= RAM_START)
                        | (ext_addr_i >= SFR_BASE);
    // Low addresses wrap here but are internal
    assign ext_offset   = {1'b0, ext_addr_i} - {1'b0, ROM_SIZE};
    assign ext_select_o = expand_on & ~internal_hit
                        & (ext_offset < window_size);

    // Read data taken from port 4 while the read strobe is active
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ext_rdata_o <= 8'h00;
        end else if (ext_select_o && ext_rd_i && !ext_addr_phase_i) begin
            ext_rdata_o <= pin_level_i[IDX_P4];
        end
    end

    // ==========================================================
    // Pin drive
    // ==========================================================
    logic [7:0] high_addr_pins;
    logic       bus_cycle;

    assign bus_cycle = ext_select_o & (ext_rd_i | ext_wr_i);

    // Upper address pins of port 5 grow with the window size
    always_comb begin
        unique case (expansion_code)
            MODE_EXPAND_4K:   high_addr_pins = 8'h0F;
            MODE_EXPAND_16K:  high_addr_pins = 8'h3F;
            MODE_EXPAND_FULL: high_addr_pins = 8'hFF;
            default:          high_addr_pins = 8'h00;
        endcase
    end

    assign seg_enable_o[0] = port5_segment_select;
    assign seg_enable_o[1] = port7_segment_select;
    assign seg_enable_o[2] = port12_segment_select;
    assign seg_enable_o[3] = port13_segment_select;
    assign seg_enable_o[4] = port14_segment_select;

    // Port drive, then segment hand-over, then bus overrides
    always_comb begin
        for (int i = 0; i < NUM_PORTS; i++) begin
            pin_out_o[i] = latch[i];
            pin_oe_o[i]  = ~direction[i];
        end

        // Open drain only pulls low, so a 1 releases the pin
        pin_oe_o[IDX_P2] = ~direction[IDX_P2]
                         & ~(port2_drive_type & latch[IDX_P2]);
        // LCD-owned pins are let go by the port
        pin_oe_o[IDX_P5]  = pin_oe_o[IDX_P5]  & ~port5_segment_select;
        pin_oe_o[IDX_P7]  = pin_oe_o[IDX_P7]  & ~port7_segment_select;
        pin_oe_o[IDX_P12] = pin_oe_o[IDX_P12] & ~port12_segment_select;
        pin_oe_o[IDX_P13] = pin_oe_o[IDX_P13] & ~port13_segment_select;
        pin_oe_o[IDX_P14] = pin_oe_o[IDX_P14] & ~port14_segment_select;

        if (expand_on) begin
            // Port 4: address in the latch phase, then write data
            pin_out_o[IDX_P4] = ext_addr_phase_i ? ext_addr_i[7:0]
                                                 : ext_wdata_i;
            pin_oe_o[IDX_P4]  = {8{bus_cycle & (ext_addr_phase_i
                                                | ext_wr_i)}};
            for (int b = 0; b < 8; b++) begin
                if (high_addr_pins[b]) begin
                    pin_out_o[IDX_P5][b] = ext_addr_i[8 + b];
                    pin_oe_o[IDX_P5][b]  = 1'b1;
                end
            end

            // Read and write strobes are active low and idle high; the address strobe is active high
            pin_out_o[IDX_P6][PIN_READ_STROBE] =
                ~(bus_cycle & ext_rd_i & ~ext_addr_phase_i);
            pin_out_o[IDX_P6][PIN_WRITE_STROBE] =
                ~(bus_cycle & ext_wr_i & ~ext_addr_phase_i);
            pin_out_o[IDX_P6][PIN_ADDR_STROBE] = bus_cycle & ext_addr_phase_i;
            pin_oe_o[IDX_P6][PIN_READ_STROBE]  = 1'b1;
            pin_oe_o[IDX_P6][PIN_WRITE_STROBE] = 1'b1;
            pin_oe_o[IDX_P6][PIN_ADDR_STROBE]  = 1'b1;
        end
    end

endmodule : port_function_control

// [testbench/port_function_control_sva.sv]
`timescale 1ns/10ps
module port_function_control_sva
    import port_function_control_pkg::*;
#(
    parameter logic [15:0] ROM_SIZE  = 16'h8000,
    parameter logic [15:0] RAM_START = 16'hFB00
) (
    input wire logic        sys_clk_i,
    input wire logic        rstn_i,
    input wire logic [15:0] sfr_addr_i,
    input wire logic        sfr_wr_i,
    input wire logic        sfr_bit_wr_i,
    input wire logic [2:0]  sfr_bit_sel_i,
    input wire logic        sfr_bit_val_i,
    input wire logic [7:0]  sfr_wdata_i,
    input wire logic        sfr_rd_i,
    input wire logic [7:0]  sfr_rdata_o,
    input wire logic [15:0] ext_addr_i,
    input wire logic        ext_rd_i,
    input wire logic        ext_addr_phase_i,
    input wire logic        ext_select_o,
    input wire logic [7:0]  ext_rdata_o,
    input wire logic [7:0]  pin_level_i [NUM_PORTS],
    input wire logic [7:0]  pin_out_o [NUM_PORTS],
    input wire logic [7:0]  pin_oe_o [NUM_PORTS],
    input wire logic [7:0]  seg_enable_o [5],
    input wire logic [2:0]  expansion_code_o
);
    default clocking dc @(posedge sys_clk_i); endclocking
    default disable iff (!rstn_i);
    logic [4:0] drive_type;
    // ====================
    // Shadow of drive type, which has no port of its own
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i)
            drive_type <= 5'h00;
        else if (sfr_bit_wr_i && sfr_addr_i == ADDR_PORT2_DRIVE_TYPE
                 && sfr_bit_sel_i < 3'h5)
            drive_type[sfr_bit_sel_i] <= sfr_bit_val_i;
        else if (sfr_wr_i && sfr_addr_i == ADDR_PORT2_DRIVE_TYPE)
            drive_type <= sfr_wdata_i[4:0];
    end
    // ====================
    // Assertions
    reset_state_a: assert property ($rose(rstn_i) |->
        expansion_code_o == 3'h0 && seg_enable_o[2] == 8'h00
        && pin_oe_o[IDX_P7] == 8'h00) else $error("reset state wrong");
    mode_write_a: assert property (sfr_wr_i && !sfr_bit_wr_i
        && sfr_addr_i == ADDR_MEMORY_EXPANSION_MODE |=>
        expansion_code_o == $past(sfr_wdata_i[2:0]))
        else $error("mode field not written");
    mode_read_a: assert property (sfr_rd_i
        && sfr_addr_i == ADDR_MEMORY_EXPANSION_MODE |=>
        sfr_rdata_o == {5'h00, expansion_code_o})
        else $error("mode read wrong");
    open_drain_a: assert property (
        (drive_type & pin_out_o[IDX_P2][4:0] & pin_oe_o[IDX_P2][4:0]) == 5'h00)
        else $error("open drain pin driven high");
    seg_release_a: assert property (expansion_code_o == 3'h0 |->
        (seg_enable_o[0] & pin_oe_o[IDX_P5]) == 8'h00
        && (seg_enable_o[1] & pin_oe_o[IDX_P7]) == 8'h00)
        else $error("segment pin still driven");
    read_keeps_latch_a: assert property (
        sfr_rd_i && !sfr_wr_i && !sfr_bit_wr_i |=> $stable(pin_out_o[IDX_P7]))
        else $error("read changed latch");
    single_chip_a: assert property (expansion_code_o == 3'h0
        |-> !ext_select_o) else $error("external select in single chip");
    addr_phase_a: assert property (ext_select_o && ext_addr_phase_i |->
        pin_out_o[IDX_P4] == ext_addr_i[7:0] && pin_oe_o[IDX_P4] == 8'hFF
        && pin_out_o[IDX_P6][PIN_ADDR_STROBE])
        else $error("address phase pins wrong");
    read_phase_a: assert property (ext_select_o && ext_rd_i
        && !ext_addr_phase_i |-> !pin_out_o[IDX_P6][PIN_READ_STROBE]
        && pin_oe_o[IDX_P4] == 8'h00 ##1
        ext_rdata_o == $past(pin_level_i[IDX_P4]))
        else $error("read phase wrong");
    full_window_a: assert property (expansion_code_o == 3'h7
        && ext_rd_i && ext_addr_i >= ROM_SIZE && ext_addr_i < RAM_START
        |-> ext_select_o) else $error("full mode address not external");
    ext_read_c: cover property (ext_select_o && ext_rd_i && !ext_addr_phase_i);
    bit_write_c: cover property (sfr_bit_wr_i);
    full_mode_c: cover property (expansion_code_o == 3'h7 && ext_select_o);
endmodule : port_function_control_sva

bind port_function_control port_function_control_sva #(
    .ROM_SIZE(ROM_SIZE), .RAM_START(RAM_START)) u_sva (
    .sys_clk_i, .rstn_i, .sfr_addr_i, .sfr_wr_i, .sfr_bit_wr_i,
    .sfr_bit_sel_i, .sfr_bit_val_i, .sfr_wdata_i, .sfr_rd_i, .sfr_rdata_o,
    .ext_addr_i, .ext_rd_i, .ext_addr_phase_i, .ext_select_o, .ext_rdata_o,
    .pin_level_i, .pin_out_o, .pin_oe_o, .seg_enable_o, .expansion_code_o);

// [testbench/pin_world.sv]
`timescale 1ns/10ps
module pin_world
    import port_function_control_pkg::*;
(
    input  wire logic       sys_clk_i,
    input  wire logic       rstn_i,
    input  wire logic [7:0] pin_out_i [NUM_PORTS],
    input  wire logic [7:0] pin_oe_i [NUM_PORTS],
    input  wire logic [7:0] ext_level_i [NUM_PORTS],
    output logic      [7:0] pin_level_o [NUM_PORTS]
);
    logic [7:0] addr_lo;
    logic       rd_act;
    // ====================
    // External memory takes the low address while the latch strobe is high
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i)
            addr_lo <= 8'h00;
        else if (pin_oe_i[IDX_P6][7] && pin_out_i[IDX_P6][7])
            addr_lo <= pin_out_i[IDX_P4];
    end
    assign rd_act = pin_oe_i[IDX_P6][4] && !pin_out_i[IDX_P6][4];
    // Undriven lines show the board level, standing in for pulls; port 4 under the read strobe shows memory data
    always_comb begin
        for (int p = 0; p < NUM_PORTS; p++) begin
            pin_level_o[p] = (pin_oe_i[p] & pin_out_i[p]) | (~pin_oe_i[p] &
                ((p == IDX_P4 && rd_act) ? (addr_lo ^ 8'hA5) : ext_level_i[p]));
        end
    end
endmodule : pin_world

// [testbench/port_function_control_tb_top.sv]
`timescale 1ns/10ps
module port_function_control_tb_top
    import port_function_control_pkg::*;
;
    typedef struct {
        logic [15:0] addr;
        logic [7:0]  wdata;
        logic [7:0]  rdata;
    } row_t;
    logic        sys_clk_i, rstn_i, sfr_wr_i, sfr_bit_wr_i, sfr_bit_val_i;
    logic        sfr_rd_i, ext_rd_i, ext_wr_i, ext_addr_phase_i, ext_select_o;
    logic [15:0] sfr_addr_i, ext_addr_i;
    logic [2:0]  sfr_bit_sel_i, expansion_code_o;
    logic [7:0]  sfr_wdata_i, sfr_rdata_o, ext_wdata_i, ext_rdata_o;
    logic [7:0]  pin_level_i [NUM_PORTS];
    logic [7:0]  pin_out_o [NUM_PORTS];
    logic [7:0]  pin_oe_o [NUM_PORTS];
    logic [7:0]  ext_level [NUM_PORTS];
    logic [7:0]  seg_enable_o [5];
    int          error_cnt = 0;
    int          comparisons = 0;
    // Rows 0-6 are the seven select registers: drive type, mode, then the five segment selects
    row_t rows [11] = '{'{16'hFF52, 8'hFF, 8'h1F}, '{16'hFF47, 8'hFF, 8'h07},
        '{16'hFF55, 8'hA5, 8'hA5}, '{16'hFF57, 8'h5A, 8'h5A},
        '{16'hFF5C, 8'hFF, 8'hFF}, '{16'hFF5D, 8'h00, 8'h00},
        '{16'hFF5E, 8'hFF, 8'hFF}, '{16'hFF60, 8'hA5, 8'h00},
        '{16'hFF27, 8'hF0, 8'hF0}, '{16'hFF47, 8'h00, 8'h00},
        '{16'hFF57, 8'h00, 8'h00}};
    logic [2:0]  mcode [4] = '{3'h3, 3'h4, 3'h5, 3'h7};
    logic [15:0] maddr [4] = '{16'h8012, 16'h8A12, 16'h9A12, 16'h9A12};
    logic [7:0]  mmask [4] = '{8'h00, 8'h0F, 8'h3F, 8'hFF};

    port_function_control dut (.sys_clk_i, .rstn_i, .sfr_addr_i, .sfr_wr_i,
        .sfr_bit_wr_i, .sfr_bit_sel_i, .sfr_bit_val_i, .sfr_wdata_i,
        .sfr_rd_i, .sfr_rdata_o, .ext_addr_i, .ext_wdata_i, .ext_rd_i,
        .ext_wr_i, .ext_addr_phase_i, .ext_select_o, .ext_rdata_o,
        .pin_level_i, .pin_out_o, .pin_oe_o, .seg_enable_o, .expansion_code_o);
    pin_world board (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i),
        .pin_out_i(pin_out_o), .pin_oe_i(pin_oe_o), .ext_level_i(ext_level),
        .pin_level_o(pin_level_i));

    // ====================
    // Clock, 100 ns period
    initial begin
        sys_clk_i = 1'b0;
        forever #50 sys_clk_i = ~sys_clk_i;
    end
    // Verdict task, shared by the main sequence and the watchdog
    task automatic give_verdict;
        if (error_cnt == 0 && comparisons > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : give_verdict
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // Register bus: strobes last exactly one cycle
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge sys_clk_i) #10 sfr_addr_i = a;
        sfr_wdata_i = d;
        sfr_wr_i = 1'b1;
        @(posedge sys_clk_i) #10 sfr_wr_i = 1'b0;
    endtask : wr
    task automatic bwr(input logic [15:0] a, input logic [2:0] b, input logic v);
        @(posedge sys_clk_i) #10 sfr_addr_i = a;
        sfr_bit_sel_i = b;
        sfr_bit_val_i = v;
        sfr_bit_wr_i = 1'b1;
        @(posedge sys_clk_i) #10 sfr_bit_wr_i = 1'b0;
    endtask : bwr
    task automatic rd(input logic [15:0] a, input logic [7:0] exp);
        @(posedge sys_clk_i) #10 sfr_addr_i = a;
        sfr_rd_i = 1'b1;
        @(posedge sys_clk_i) #10 sfr_rd_i = 1'b0;
        chk(sfr_rdata_o, exp);
    endtask : rd
    // External cycle start; compares follow after a short settle
    task automatic ext_go(input logic [15:0] a, input logic r, input logic w);
        @(posedge sys_clk_i) #10 ext_addr_i = a;
        ext_rd_i = r;
        ext_wr_i = w;
        ext_addr_phase_i = 1'b1;
        #1;
    endtask : ext_go

    // ====================
    // Main sequence
    initial begin
        {rstn_i, sfr_wr_i, sfr_bit_wr_i, sfr_bit_val_i, sfr_rd_i} = 5'h00;
        {ext_rd_i, ext_wr_i, ext_addr_phase_i} = 3'h0;
        {sfr_addr_i, ext_addr_i, sfr_bit_sel_i} = 35'h0;
        {sfr_wdata_i, ext_wdata_i} = 16'h005C;
        foreach (ext_level[p]) ext_level[p] = 8'hFF;
        ext_level[IDX_P7] = 8'h96;
        repeat (10) @(posedge sys_clk_i);
        #10 rstn_i = 1'b1;
        for (int i = 0; i < 7; i++) rd(rows[i].addr, 8'h00);
        rd(16'hFF27, 8'hFF);
        foreach (rows[i]) begin
            wr(rows[i].addr, rows[i].wdata);
            rd(rows[i].addr, rows[i].rdata);
        end
        // Mixed port 7: low nibble out, high nibble in
        wr(16'hFF07, 8'h3C);
        chk(pin_out_o[IDX_P7] & 8'h0F, 8'h0C);
        chk(pin_oe_o[IDX_P7], 8'h0F);
        rd(16'hFF07, 8'h9C);
        chk(pin_out_o[IDX_P7] & 8'h0F, 8'h0C);
        wr(16'hFF07, 8'hA0);
        chk(pin_oe_o[IDX_P7], 8'h0F);
        bwr(16'hFF07, 3'h2, 1'b1);
        wr(16'hFF27, 8'h00);
        chk(pin_out_o[IDX_P7], 8'h94);
        // Port 2 open drain on pin 0 only
        wr(16'hFF52, 8'h01);
        wr(16'hFF02, 8'h03);
        wr(16'hFF22, 8'h00);
        chk(pin_oe_o[IDX_P2] & 8'h03, 8'h02);
        wr(16'hFF02, 8'h02);
        chk(pin_oe_o[IDX_P2] & 8'h03, 8'h03);
        // Segment hand-over and refused bit write
        wr(16'hFF55, 8'h00);
        bwr(16'hFF55, 3'h0, 1'b1);
        chk(seg_enable_o[0], 8'h01);
        wr(16'hFF25, 8'h00);
        chk(pin_oe_o[IDX_P5], 8'hFE);
        bwr(16'hFF5C, 3'h3, 1'b0);
        rd(16'hFF5C, 8'hFF);
        wr(16'hFF55, 8'h00);
        // Every expansion code with a window, one read cycle each
        foreach (mcode[i]) begin
            wr(16'hFF47, {5'h00, mcode[i]});
            ext_go(maddr[i], 1'b1, 1'b0);
            chk({7'h00, ext_select_o}, 8'h01);
            chk(pin_oe_o[IDX_P4], 8'hFF);
            chk(pin_out_o[IDX_P5] & mmask[i], maddr[i][15:8] & mmask[i]);
            @(posedge sys_clk_i) #10 ext_addr_phase_i = 1'b0;
            @(posedge sys_clk_i) #10 ext_rd_i = 1'b0;
            chk(ext_rdata_o, 8'hB7);
        end
        ext_go(16'hFB10, 1'b1, 1'b0);
        chk({7'h00, ext_select_o}, 8'h00);
        ext_go(16'h0100, 1'b1, 1'b0);
        chk({7'h00, ext_select_o}, 8'h00);
        ext_go(16'h9A34, 1'b0, 1'b1);
        @(posedge sys_clk_i) #10 ext_addr_phase_i = 1'b0;
        #1 chk(pin_out_o[IDX_P4], 8'h5C);
        chk(pin_out_o[IDX_P6] & 8'h20, 8'h00);
        @(posedge sys_clk_i) #10 ext_wr_i = 1'b0;
        wr(16'hFF47, 8'h00);
        ext_go(16'h9A34, 1'b1, 1'b0);
        chk({7'h00, ext_select_o}, 8'h00);
        // Second reset in mid-run
        @(posedge sys_clk_i) #10 rstn_i = 1'b0;
        ext_rd_i = 1'b0;
        repeat (2) @(posedge sys_clk_i);
        #10 rstn_i = 1'b1;
        chk(seg_enable_o[2], 8'h00);
        chk(pin_oe_o[IDX_P2], 8'h00);
        rd(16'hFF52, 8'h00);
        give_verdict;
    end
    // Watchdog: the sequence needs well under 1000 cycles
    initial begin
        #2000000;
        error_cnt++;
        give_verdict;
    end
endmodule : port_function_control_tb_top
